// ---- rtl/picx_arb.sv ----
`timescale 1ns/1ps
// combinational winner search over user sources
module picx_arb
   import picx_pkg::*;
#(
   parameter int N = 8
)(
   input  wire logic [N-1:0]   req_i,  // pending and enabled
   input  wire logic [3*N-1:0] prio_i, // packed priorities
   output logic      [2:0]     lvl_o,  // winning level, 0 none
   output logic      [2:0]     idx_o   // winning index
);
   always_comb
   begin
      lvl_o = 3'h0;
      idx_o = 3'h0;
      // lowest index wins a tie; zero priority never wins
      for (int i = 0; i < N; i++)
      begin
         if (req_i[i] && (prio_i[3*i +: 3] > lvl_o))
         begin
            lvl_o = prio_i[3*i +: 3];
            idx_o = 3'(i);
         end
      end
   end
endmodule : picx_arb

// ---- rtl/picx_ctrl.sv ----
`timescale 1ns/1ps
// priority interrupt controller with wishbone registers
module picx_ctrl
   import picx_pkg::*;
#(
   parameter int TIMED_DISABLE_INSTR_DEF = 5 // unused; reset clears the timed disable count to 0
)(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [7:0]       adr_i,
   input  wire logic [31:0]      dat_i,
   input  wire logic [3:0]       sel_i,
   input  wire logic             we_i,
   input  wire logic             cyc_i,
   input  wire logic             stb_i,
   output logic      [31:0]      dat_o,
   output logic                  ack_o,
   output logic                  err_o,
   input  wire logic [NSRC-1:0]  src_i,      // one-cycle source events
   input  wire logic [NTRAP-1:0] trap_i,     // one-cycle trap events
   input  wire logic             instr_i,    // one instruction retired
   input  wire logic             ret_i,      // handler return pulse
   input  wire logic [15:0]      pc_i,       // pc to stack on entry
   output logic                  take_o,     // entry pulse to cpu
   output logic      [3:0]       vec_o,      // vector, trap if msb
   output logic      [15:0]      ret_pc_o,   // restored pc
   output logic      [3:0]       cpu_lvl_o   // current cpu level
);
   // state registers
   logic [NSRC-1:0]   flag_reg, flag_next;
   logic [NSRC-1:0]   ena_reg, ena_next;
   logic [3*NSRC-1:0] prio_reg, prio_next;
   logic [NTRAP-1:0]  trap_reg, trap_next;
   logic              nst_reg, nst_next;
   logic [7:0]        srl_reg, srl_next;   // status low byte
   logic              msb_reg, msb_next;   // level bit 3
   logic [7:0]        timed_disable_instr_reg, timed_disable_instr_next; // timed disable count
   logic [3:0]        depth_reg, depth_next;
   logic              act_reg, act_next;   // handler running
   logic [24:0]       stk_reg [0:7];       // pc, srl, msb per nest
   logic [24:0]       stk_next;
   logic              push, pop;
   logic [31:0]       dat_next;
   logic              ack_next, err_next, take_next;
   logic [3:0]        vec_next;
   logic [15:0]       rpc_next;
   // arbiter
   logic [2:0]        win_lvl, win_idx;
   logic [3:0]        cur_lvl;
   logic              wr, rd_ok;
   logic [1:0]        trap_hit;
   logic              trap_any;

   assign cur_lvl = {msb_reg, srl_reg[STATUS_LVL_LSB +: 3]};
   assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];

   picx_arb #(.N(NSRC)) u_arb (
      .req_i  (flag_reg & ena_reg),
      .prio_i (prio_reg),
      .lvl_o  (win_lvl),
      .idx_o  (win_idx)
   );

   // trap with lowest index wins
   always_comb
   begin
      trap_any = |trap_reg;
      trap_hit = 2'h0;
      for (int t = NTRAP - 1; t >= 0; t--)
      begin
         if (trap_reg[t])
         begin
            trap_hit = 2'(t);
         end
      end
   end

   // next-state for registers, stack and cpu interface
   always_comb
   begin
      flag_next  = flag_reg | src_i;
      trap_next  = trap_reg | trap_i;
      ena_next   = ena_reg;
      prio_next  = prio_reg;
      nst_next   = nst_reg;
      srl_next   = srl_reg;
      msb_next   = msb_reg;
      timed_disable_instr_next  = (instr_i && timed_disable_instr_reg != 8'h0) ? timed_disable_instr_reg - 8'h1 : timed_disable_instr_reg;
      depth_next = depth_reg;
      act_next   = act_reg;
      push       = 1'b0;
      pop        = 1'b0;
      stk_next   = {pc_i, srl_reg, msb_reg};
      take_next  = 1'b0;
      vec_next   = vec_o;
      rpc_next   = ret_pc_o;
      // software writes; a same-cycle event keeps its flag set
      if (wr)
      begin
         unique case (adr_i)
            OFS_CORE:
               if (!dat_i[CORE_MSB_BIT])
                  msb_next = 1'b0;
            OFS_ICON1:
            begin
               if (sel_i[1])
                  nst_next = dat_i[NESTING_DISABLE_BIT];
               trap_next = (trap_reg & dat_i[NTRAP-1:0]) | trap_i;
            end
            OFS_FLAG:  flag_next = (flag_reg & dat_i[NSRC-1:0]) | src_i;
            OFS_ENA:   ena_next = dat_i[NSRC-1:0];
            OFS_PRIO_LO: prio_next[11:0] = dat_i[11:0];
            OFS_PRIO_HI: prio_next[23:12] = dat_i[11:0];
            OFS_STATUS: srl_next = dat_i[7:0];
            OFS_TIMED_DISABLE_INSTR:  timed_disable_instr_next = dat_i[7:0];
            default: ;
         endcase
      end
      // entry after return: traps need msb clear and a free stack slot, user sources need level and windows
      if (ret_i && depth_reg != 4'h0)
      begin
         pop        = 1'b1;
         depth_next = depth_reg - 4'h1;
         rpc_next   = stk_reg[depth_reg[2:0] - 3'h1][24:9];
         srl_next   = stk_reg[depth_reg[2:0] - 3'h1][8:1];
         msb_next   = stk_reg[depth_reg[2:0] - 3'h1][0];
         act_next   = (depth_reg != 4'h1);
      end
      else if (trap_any && !msb_reg && depth_reg != 4'h8)
      begin
         push       = 1'b1;
         take_next  = 1'b1;
         vec_next   = TRAP_BASE | {2'h0, trap_hit};
         msb_next   = 1'b1;
         srl_next   = srl_reg | 8'he0;
         depth_next = depth_reg + 4'h1;
         act_next   = 1'b1;
      end
      else if (win_lvl != 3'h0 && {1'b0, win_lvl} > cur_lvl
               && !(win_lvl != 3'h7 && timed_disable_instr_reg != 8'h0)
               && !(nst_reg && act_reg)
               && depth_reg != 4'h8)
      begin
         push       = 1'b1;
         take_next  = 1'b1;
         vec_next   = {1'b0, win_idx};
         srl_next   = {win_lvl, srl_reg[4:0]};
         depth_next = depth_reg + 4'h1;
         act_next   = 1'b1;
      end
      // bus answer, one cycle, unmapped gets err
      ack_next = 1'b0;
      err_next = 1'b0;
      dat_next = 32'h0;
      rd_ok    = 1'b1;
      unique case (adr_i)
         OFS_CORE:    dat_next[CORE_MSB_BIT] = msb_reg;
         OFS_ICON1:   dat_next = {16'h0, nst_reg, 11'h0, trap_reg};
         OFS_FLAG:    dat_next[NSRC-1:0] = flag_reg;
         OFS_ENA:     dat_next[NSRC-1:0] = ena_reg;
         OFS_PRIO_LO: dat_next[11:0] = prio_reg[11:0];
         OFS_PRIO_HI: dat_next[11:0] = prio_reg[23:12];
         OFS_STATUS:  dat_next[7:0] = srl_reg;
         OFS_TIMED_DISABLE_INSTR:    dat_next[7:0] = timed_disable_instr_reg;
         OFS_STATE:   dat_next = {20'h0, depth_reg, cur_lvl, 3'h0, act_reg};
         default:     rd_ok = 1'b0;
      endcase
      if (cyc_i && stb_i && !ack_o && !err_o)
      begin
         ack_next = rd_ok;
         err_next = !rd_ok;
      end
      if (!rd_ok)
         dat_next = 32'h0;
   end

   // register everything
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         flag_reg  <= '0;
         ena_reg   <= '0;
         prio_reg  <= {NSRC{PRIO_RESET}};
         trap_reg  <= '0;
         nst_reg   <= 1'b0;
         srl_reg   <= 8'h0;
         msb_reg   <= 1'b0;
         timed_disable_instr_reg  <= 8'h0;
         depth_reg <= 4'h0;
         act_reg   <= 1'b0;
         dat_o     <= 32'h0;
         ack_o     <= 1'b0;
         err_o     <= 1'b0;
         take_o    <= 1'b0;
         vec_o     <= 4'h0;
         ret_pc_o  <= 16'h0;
         cpu_lvl_o <= 4'h0;
      end
      else
      begin
         flag_reg  <= flag_next;
         ena_reg   <= ena_next;
         prio_reg  <= prio_next;
         trap_reg  <= trap_next;
         nst_reg   <= nst_next;
         srl_reg   <= srl_next;
         msb_reg   <= msb_next;
         timed_disable_instr_reg  <= timed_disable_instr_next;
         depth_reg <= depth_next;
         act_reg   <= act_next;
         dat_o     <= dat_next;
         ack_o     <= ack_next;
         err_o     <= err_next;
         take_o    <= take_next;
         vec_o     <= vec_next;
         ret_pc_o  <= rpc_next;
         cpu_lvl_o <= {msb_next, srl_next[STATUS_LVL_LSB +: 3]};
      end
   end

   // entry stack, no reset needed: read only below depth
   always_ff @(posedge clk_i)
   begin
      if (push && !pop)
         stk_reg[depth_reg[2:0]] <= stk_next;
   end
endmodule : picx_ctrl

// ---- rtl/picx_pkg.sv ----
// Contract
// - cpu level is msb bit plus status field
// - msb status bit reads level above seven
// - nesting disable blocks user preemption
// - each source has writable priority field
// - reset sets every user priority to four
// - flag stays set until software clears it
// - return restores pc, status byte, level
// - trap flags persist until software clears
// - level seven blocks all user interrupts
// - only levels up to seven are maskable
// - timed disable blocks levels one to six
package picx_pkg;
   localparam int NSRC = 8; // user sources
   localparam int NTRAP = 4; // trap sources
   // register word offsets (byte addresses)
   localparam logic [7:0] OFS_CORE = 8'h00;
   localparam logic [7:0] OFS_ICON1 = 8'h04;
   localparam logic [7:0] OFS_FLAG = 8'h08;
   localparam logic [7:0] OFS_ENA = 8'h0c;
   localparam logic [7:0] OFS_PRIO_LO = 8'h10;
   localparam logic [7:0] OFS_PRIO_HI = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_TIMED_DISABLE_INSTR = 8'h1c;
   localparam logic [7:0] OFS_STATE = 8'h20;
   // field positions
   localparam int CORE_MSB_BIT = 3;
   localparam int NESTING_DISABLE_BIT = 15;
   localparam int STATUS_LVL_LSB = 5;
   // priority reset value, block-all level, trap vector base
   localparam logic [2:0] PRIO_RESET = 3'h4;
   localparam logic [2:0] LVL_BLOCK_ALL = 3'h7;
   localparam logic [3:0] TRAP_BASE = 4'h8;
endpackage : picx_pkg

// ---- tb/picx_cpu_model.sv ----
`timescale 1ns/1ps
// cpu core stand-in: follows entries, returns on request
module picx_cpu_model
   import picx_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        take_i,
   input  wire logic [3:0]  vec_i,
   input  wire logic        ret_req_i,
   output logic             ret_o,
   output logic             instr_o,
   output logic      [15:0] pc_o,
   output logic      [3:0]  last_vec_o,
   output int               takes_o
);
   // pc only moves on entry or return, so the stacked pc is unambiguous
   always_ff @(posedge clk_i)
   begin
      ret_o <= ret_req_i & ~rst_i;
      instr_o <= ~rst_i;
      if (rst_i || ret_o)
         pc_o <= 16'h1234;
      else if (take_i)
         pc_o <= {12'h010, vec_i};
      if (rst_i)
         takes_o <= 0;
      else if (take_i)
      begin
         takes_o <= takes_o + 1;
         last_vec_o <= vec_i;
      end
   end
endmodule : picx_cpu_model

// ---- tb/picx_ctrl_asserts.sv ----
`timescale 1ns/1ps
// port checker for the controller
module picx_ctrl_asserts
   import picx_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        err_o,
   input wire logic [3:0]  trap_i,
   input wire logic        take_o,
   input wire logic [3:0]  vec_o,
   input wire logic [3:0]  cpu_lvl_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // bus answers one cycle after a fresh request
   AST_ACK_LAT: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
      else $error("no bus answer");
   AST_ACK_ONE: assert property (ack_o |=> !ack_o)
      else $error("ack held");
   AST_ANS_CAUSE: assert property (ack_o || err_o |-> $past(cyc_i && stb_i))
      else $error("answer without request");
   AST_ERR_ZERO: assert property (err_o |-> dat_o == 32'h0000_0000)
      else $error("error data not zero");
   // a trap is taken two cycles later whenever the cpu level msb is clear
   AST_TRAP_TAKE: assert property (|trap_i && !cpu_lvl_o[3] |-> ##2 take_o && vec_o[3])
      else $error("trap not taken");
   AST_TRAP_LVL: assert property (take_o && vec_o[3] |-> cpu_lvl_o[3])
      else $error("trap level msb low");
   AST_USER_RISE: assert property (take_o && !vec_o[3] |-> cpu_lvl_o > $past(cpu_lvl_o) && !cpu_lvl_o[3])
      else $error("user entry not above level");
   AST_MASK_SEVEN: assert property (take_o && $past(cpu_lvl_o) >= 4'h7 |-> vec_o[3])
      else $error("user entry at level seven");
   COV_USER: cover property (take_o && !vec_o[3]);
   COV_TRAP: cover property (take_o && vec_o[3]);
   COV_ERR: cover property (err_o);
endmodule : picx_ctrl_asserts

bind picx_ctrl picx_ctrl_asserts u_chk (.*);

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
// register and event sequences against the controller
module testbench
   import picx_pkg::*;
;
   logic        clk_i, rst_i, we_i, cyc_i, stb_i, ret_req, ack_o, err_o, take_o, ret_i, instr_i;
   logic [7:0]  adr_i, src_i;
   logic [31:0] dat_i, dat_o, rd;
   logic [3:0]  sel_i, trap_i, vec_o, cpu_lvl_o, last_vec;
   logic [15:0] pc_i, ret_pc_o;
   int          failures = 0, tests_run = 0, takes, cycles = 0;

   picx_ctrl DUT (.*);
   picx_cpu_model u_cpu (.clk_i(clk_i), .rst_i(rst_i), .take_i(take_o), .vec_i(vec_o),
      .ret_req_i(ret_req), .ret_o(ret_i), .instr_o(instr_i), .pc_o(pc_i),
      .last_vec_o(last_vec), .takes_o(takes));

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // watchdog: the whole run needs a few hundred cycles
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles > 2000)
      begin
         failures++;
         end_sim();
      end
   end

   // single classic cycle, held until answered
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_i);
      adr_i <= a;
      we_i <= w;
      dat_i <= d;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      do
         @(posedge clk_i);
      while (!(ack_o || err_o));
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : wb

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk

   // one-cycle event or return request, then let entry settle
   task automatic ev(input logic [7:0] s, input logic [3:0] t, input logic r);
      @(posedge clk_i);
      src_i <= s;
      trap_i <= t;
      ret_req <= r;
      @(posedge clk_i);
      src_i <= 8'h00;
      trap_i <= 4'h0;
      ret_req <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask : ev

   task automatic end_sim();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim

   initial
   begin
      {rst_i, we_i, cyc_i, stb_i, ret_req, adr_i, src_i, dat_i, trap_i} = '0;
      rst_i = 1'b1;
      sel_i = 4'hf;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(OFS_PRIO_LO, 1'b0, 0); chk(rd, 32'h924);
      wb(OFS_PRIO_HI, 1'b0, 0); chk(rd, 32'h924);
      wb(8'h24, 1'b0, 0); chk(rd, 0);
      $display("test reset done");
      wb(OFS_FLAG, 1'b1, 0);
      wb(OFS_PRIO_LO, 1'b1, 32'h82b);
      wb(OFS_ENA, 1'b1, 32'h07);
      ev(8'h07, 0, 0); chk(32'(last_vec), 1); chk(32'(cpu_lvl_o), 5);
      ev(0, 0, 1); chk(takes, 2); chk(32'(ret_pc_o), 32'h1234);
      wb(OFS_FLAG, 1'b1, 32'hfd);
      ev(0, 0, 1); chk(32'(last_vec), 0); chk(32'(cpu_lvl_o), 3);
      wb(OFS_FLAG, 1'b1, 32'hfe);
      ev(0, 0, 1); chk(takes, 3); chk(32'(cpu_lvl_o), 0);
      $display("test user done");
      wb(OFS_PRIO_HI, 1'b1, 32'hfff);
      wb(OFS_ENA, 1'b1, 32'h17);
      wb(OFS_STATUS, 1'b1, 32'he0);
      ev(8'h10, 0, 0); chk(takes, 3); chk(32'(cpu_lvl_o), 7);
      ev(0, 4'h1, 0); chk(32'(last_vec), 8); chk(32'(cpu_lvl_o[3]), 1);
      wb(OFS_CORE, 1'b0, 0); chk(32'(rd[3]), 1);
      wb(OFS_ICON1, 1'b0, 0); chk(32'(rd[0]), 1);
      wb(OFS_ICON1, 1'b1, 0);
      ev(0, 0, 1); chk(takes, 4); chk(32'(cpu_lvl_o), 7);
      $display("test mask done");
      // timed disable holds back level six but not level seven
      wb(OFS_PRIO_HI, 1'b1, 32'h37);
      wb(OFS_ENA, 1'b1, 32'h30);
      wb(OFS_FLAG, 1'b1, 32'hef);
      wb(OFS_TIMED_DISABLE_INSTR, 1'b1, 32'hff);
      wb(OFS_STATUS, 1'b1, 0);
      ev(8'h20, 0, 0); chk(takes, 4); chk(32'(cpu_lvl_o), 0);
      ev(8'h10, 0, 0); chk(takes, 5); chk(32'(last_vec), 4);
      // let the count run out, then the held source gets in
      repeat (260) @(posedge clk_i);
      wb(OFS_FLAG, 1'b1, 32'hef);
      ev(0, 0, 1); chk(takes, 6); chk(32'(last_vec), 5);
      chk(32'(cpu_lvl_o), 6);
      $display("test disable done");
      // nesting disable keeps a higher source out of a running handler
      wb(OFS_ICON1, 1'b1, 32'h8000);
      ev(8'h10, 0, 0); chk(takes, 6);
      wb(OFS_ICON1, 1'b1, 0);
      ev(0, 0, 0); chk(takes, 7); chk(32'(last_vec), 4);
      $display("test nesting done");
      end_sim();
   end
endmodule : testbench
